//--- logic/power_channel_fault_manager.sv
// Contract
// - A control pin held off over 10 us then released starts an automatic restart.
// - Restart holds mapped enables low for restart delay, then each turns on.
// - Each enable follows exactly one control pin chosen in its channel config.
// - Overvolt or undervolt fault: disable now, after persistence, or keep running.
// - A fault-disabled channel latches off or retries after the retry delay.
// - Latch clears by control toggle, operation on command, or input reapplied.
// - Every fault or warning sets status bits and pulls the alert low.
// - Clear faults command empties status and releases the alert.
// - Warnings set status and alert but never disable an enable.
// - Input bus enable goes low on selected overvolt or undervolt faults.
// - Input bus enable releases when commanded back on after a fault.
// - Two fault zones of four channels share active-low bidirectional lines.
// - Propagate mask picks which zone lines a faulted-off channel pulls low.
// - Response mask picks which low zone lines shut that channel down.
// - A zone-tripped channel restarts once the zone line is released.
// - Propagate 0x01 and response 0x0F on shorted lines halt all channels.
// - An external low on a zone line, after 10 us deglitch, turns channels off.
// - Watchdog reset pin low for the minimum time resets the device.
// - Power good output combines the good status of the mapped outputs.
// - Optional share clock aligns input threshold sequencing across devices.
// - Input below the off threshold turns all channels off at once.
// - Off sequence drops each enable after its own turn-off delay.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "fault_mgr_cfg.svh"

module power_channel_fault_manager import fault_mgr_pkg::*; (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [1:0] control_pin,
  input wire logic vin_above_on,
  input wire logic vin_below_off,
  input wire logic share_clk_in,
  input wire logic watchdog_reset_in_n,
  input wire logic [7:0] ov_fault_cmp,
  input wire logic [7:0] uv_fault_cmp,
  input wire logic [7:0] ov_warn,
  input wire logic [7:0] uv_warn,
  input wire logic [7:0] chan_good,
  input wire logic [3:0] zone_fault_line_n_in,
  output logic [3:0] zone_fault_line_n_out,
  output logic [3:0] zone_fault_line_n_oe,
  output logic [7:0] converter_enable,
  output logic input_bus_enable,
  output logic alert_out_n,
  output logic power_good_out
);

  // Address match shared by the write and read decoders.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Every pin input except the warnings and chan_good passes two flip-flops; only the second stage is read.
  logic [25:0] sync1;
  logic [25:0] sync2;
  always_ff @(posedge ref_clk) begin
    sync1 <= {control_pin, vin_above_on, vin_below_off, share_clk_in, watchdog_reset_in_n,
              ov_fault_cmp, uv_fault_cmp, zone_fault_line_n_in};
    sync2 <= sync1;
  end
  wire [1:0] ctrl = sync2[25:24];
  wire vin_on_lvl = sync2[23];
  wire vin_off_lvl = sync2[22];
  wire share_lvl = sync2[21];
  wire wd_lvl_n = sync2[20];
  wire [7:0] ov_now = sync2[19:12];
  wire [7:0] uv_now = sync2[11:4];
  wire [3:0] line_n = sync2[3:0];

  // Watchdog pin low long enough acts as a reset of all other logic.
  logic [7:0] wd_cnt;
  logic wd_rst;
  always_ff @(posedge ref_clk) begin
    if (srst || wd_lvl_n) begin
      wd_cnt <= 8'h00;
      wd_rst <= 1'b0;
    end else if (wd_cnt >= 8'(`RESET_CYCLES - 1)) begin
      wd_rst <= 1'b1;
    end else begin
      wd_cnt <= wd_cnt + 8'h01;
    end
  end
  wire core_rst = srst | wd_rst;

  // Microsecond tick, so that every delay field counts in microseconds.
  logic [5:0] pre;
  wire tick = (pre == `TICK_LAST);
  always_ff @(posedge ref_clk) begin
    if (core_rst || tick) pre <= 6'h00;
    else pre <= pre + 6'h01;
  end

  // Software registers.
  logic [31:0] chan_cfg [8];
  logic [31:0] global_config;
  logic op_on;
  logic [15:0] restart_delay;
  logic [15:0] retry_delay;
  logic [7:0] persist_limit;
  logic [7:0] input_cut_on_overvolt;
  logic [7:0] input_cut_on_undervolt;
  logic [7:0] power_good_map;
  logic [31:0] status;

  wire cfg_wr = wr && (addr[7:5] == 3'h0);
  wire op_wr = wr && hit(addr, `REG_OPERATION);
  wire op_on_cmd = op_wr && wdata[`OP_ON];
  wire clear_cmd = wr && hit(addr, `REG_CLEAR_FAULTS);
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      for (int k = 0; k < 8; k++) chan_cfg[k] <= `RST_WORD;
      global_config <= `RST_WORD;
      op_on <= `RST_OP;
      restart_delay <= 16'h0000;
      retry_delay <= 16'h0000;
      persist_limit <= 8'h00;
      input_cut_on_overvolt <= 8'h00;
      input_cut_on_undervolt <= 8'h00;
      power_good_map <= `RST_PG_MAP;
    end else if (wr) begin
      if (cfg_wr) chan_cfg[addr[4:2]] <= wdata;
      if (hit(addr, `REG_GLOBAL_CFG)) global_config <= wdata;
      if (op_wr) op_on <= wdata[`OP_ON];
      if (hit(addr, `REG_RESTART_DELAY)) restart_delay <= wdata[15:0];
      if (hit(addr, `REG_RETRY_DELAY)) retry_delay <= wdata[15:0];
      if (hit(addr, `REG_PERSIST)) persist_limit <= wdata[7:0];
      if (hit(addr, `REG_CUT_OV)) input_cut_on_overvolt <= wdata[7:0];
      if (hit(addr, `REG_CUT_UV)) input_cut_on_undervolt <= wdata[7:0];
      if (hit(addr, `REG_PG_MAP)) power_good_map <= wdata[7:0];
    end
  end

  // Input threshold state; with sharing on it moves only on a shared clock
  // edge so that all devices on the line sequence together.
  logic vin_ok;
  logic share_prev;
  wire share_go = !global_config[`GCFG_VIN_SHARE] || (share_lvl && !share_prev);
  wire next_vin_ok = !share_go ? vin_ok : (vin_off_lvl ? 1'b0 : (vin_on_lvl ? 1'b1 : vin_ok));
  wire vin_rise = next_vin_ok && !vin_ok;
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      vin_ok <= 1'b0;
      share_prev <= 1'b0;
    end else begin
      vin_ok <= next_vin_ok;
      share_prev <= share_lvl;
    end
  end

  // Control pins: off time is measured so that a long enough pulse opens
  // a restart window during which the mapped channels stay off.
  logic [1:0] ctrl_prev;
  logic [3:0] off_cnt [2];
  logic [15:0] hold_cnt [2];
  wire [1:0] ctrl_rise = ctrl & ~ctrl_prev;
  logic [1:0] restart_pulse;
  logic [1:0] restart_hold;
  for (genvar p = 0; p < 2; p++) begin : g_ctrl
    assign restart_pulse[p] = ctrl_rise[p] && (off_cnt[p] > `RESTART_MIN_US) &&
                              (restart_delay != 16'h0000);
    assign restart_hold[p] = (hold_cnt[p] != 16'h0000);
    always_ff @(posedge ref_clk) begin
      if (core_rst) begin
        off_cnt[p] <= 4'h0;
        hold_cnt[p] <= 16'h0000;
      end else begin
        if (ctrl[p]) off_cnt[p] <= 4'h0;
        else if (tick && off_cnt[p] != 4'hf) off_cnt[p] <= off_cnt[p] + 4'h1;
        if (restart_pulse[p]) hold_cnt[p] <= restart_delay;
        else if (tick && restart_hold[p]) hold_cnt[p] <= hold_cnt[p] - 16'h0001;
      end
    end
  end
  // Reset to the idle high level, so that a pin already on is not taken for a rise.
  always_ff @(posedge ref_clk) begin
    if (core_rst) ctrl_prev <= `RST_CTRL_PREV;
    else ctrl_prev <= ctrl;
  end

  // Zone lines count as low only after a steady 10 us low.
  logic [3:0] low_cnt [4];
  logic [3:0] zone_low;
  for (genvar z = 0; z < 4; z++) begin : g_zone
    assign zone_low[z] = (low_cnt[z] == `DEGLITCH_US);
    always_ff @(posedge ref_clk) begin
      if (core_rst || line_n[z]) low_cnt[z] <= 4'h0;
      else if (tick && !zone_low[z]) low_cnt[z] <= low_cnt[z] + 4'h1;
    end
  end

  // Per-channel sequencers.
  chan_state_e state [8];
  chan_state_e next_state [8];
  logic [15:0] cnt [8];
  logic [15:0] next_cnt [8];
  logic [7:0] faulted;
  logic [7:0] latched;
  logic [7:0] zone_trip;
  logic [7:0] fault_trip;
  for (genvar i = 0; i < 8; i++) begin : g_chan
    wire [31:0] cfg = chan_cfg[i];
    wire sel = cfg[`CFG_CTRL_SEL];
    wire [1:0] ov_resp = cfg[`CFG_OV_RESP +: 2];
    wire [1:0] uv_resp = cfg[`CFG_UV_RESP +: 2];
    wire retry = cfg[`CFG_RETRY];
    wire [1:0] zl = zone_low[2 * (i / 4) +: 2];
    wire run = op_on && ctrl[sel] && vin_ok && !restart_hold[sel];
    wire imm = (ov_now[i] && ov_resp == `RESP_IMMEDIATE) ||
               (uv_now[i] && uv_resp == `RESP_IMMEDIATE);
    wire pers = (ov_now[i] && ov_resp == `RESP_PERSIST) ||
                (uv_now[i] && uv_resp == `RESP_PERSIST);
    wire clr_latch = ctrl_rise[sel] || op_on_cmd || vin_rise;
    assign zone_trip[i] = |(cfg[`CFG_RESPONSE +: 2] & zl);
    assign fault_trip[i] = imm || (pers && cnt[i] >= {8'h00, persist_limit});
    assign faulted[i] = (state[i] == CH_FAULTED);
    assign latched[i] = faulted[i] && !retry;

    // Next state; input loss overrides everything but a faulted state and warnings never enter here.
    always_comb begin
      next_state[i] = state[i];
      next_cnt[i] = cnt[i];
      if (!vin_ok && state[i] != CH_FAULTED) begin
        next_state[i] = CH_OFF;
      end else begin
        case (state[i])
          CH_OFF: begin
            if (run && !zone_trip[i]) begin
              next_state[i] = CH_DELAY_ON;
              next_cnt[i] = {8'h00, cfg[`CFG_TON +: 8]};
            end
          end
          CH_DELAY_ON: begin
            if (!run) next_state[i] = CH_OFF;
            else if (zone_trip[i]) next_state[i] = CH_ZONE_HOLD;
            else if (cnt[i] == 16'h0000) next_state[i] = CH_ON;
            else if (tick) next_cnt[i] = cnt[i] - 16'h0001;
          end
          CH_ON: begin
            if (fault_trip[i]) begin
              next_state[i] = CH_FAULTED;
              next_cnt[i] = retry_delay;
            end else if (zone_trip[i]) begin
              next_state[i] = CH_ZONE_HOLD;
            end else if (!run) begin
              next_state[i] = CH_DELAY_OFF;
              next_cnt[i] = {8'h00, cfg[`CFG_TOFF +: 8]};
            end else if (!pers) begin
              next_cnt[i] = 16'h0000;
            end else if (tick) begin
              next_cnt[i] = cnt[i] + 16'h0001;
            end
          end
          CH_DELAY_OFF: begin
            if (fault_trip[i]) begin
              next_state[i] = CH_FAULTED;
              next_cnt[i] = retry_delay;
            end else if (zone_trip[i]) next_state[i] = CH_ZONE_HOLD;
            else if (restart_pulse[sel] || cnt[i] == 16'h0000) next_state[i] = CH_OFF;
            else if (run) next_state[i] = CH_ON;
            else if (tick) next_cnt[i] = cnt[i] - 16'h0001;
          end
          CH_FAULTED: begin
            if (retry) begin
              if (cnt[i] == 16'h0000) next_state[i] = CH_OFF;
              else if (tick) next_cnt[i] = cnt[i] - 16'h0001;
            end else if (clr_latch) begin
              next_state[i] = CH_OFF;
            end
          end
          CH_ZONE_HOLD: begin
            if (!zone_trip[i]) next_state[i] = CH_OFF;
          end
          default: next_state[i] = CH_OFF;
        endcase
      end
    end

    always_ff @(posedge ref_clk) begin
      if (core_rst) begin
        state[i] <= CH_OFF;
        cnt[i] <= 16'h0000;
        converter_enable[i] <= 1'b0;
      end else begin
        state[i] <= next_state[i];
        cnt[i] <= next_cnt[i];
        converter_enable[i] <= (next_state[i] == CH_ON) || (next_state[i] == CH_DELAY_OFF);
      end
    end
  end

  // Open-drain zone lines: only ever pull low, the wire does the AND.
  logic [3:0] pull;
  always_comb begin
    pull = 4'h0;
    for (int c = 0; c < 8; c++) begin
      if (faulted[c]) pull[2 * (c / 4) +: 2] = pull[2 * (c / 4) +: 2] |
                                              chan_cfg[c][`CFG_PROPAGATE +: 2];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (core_rst) zone_fault_line_n_oe <= 4'h0;
    else zone_fault_line_n_oe <= pull;
  end
  assign zone_fault_line_n_out = 4'h0;

  // Sticky status; a new event in the clear cycle survives the clear.
  wire [31:0] status_set = {uv_warn, ov_warn, uv_now, ov_now};
  wire [31:0] next_status = (clear_cmd ? 32'h0000_0000 : status) | status_set;
  wire cut_set = |((ov_now & input_cut_on_overvolt) | (uv_now & input_cut_on_undervolt));
  wire cut_clr = op_on_cmd || (|ctrl_rise);
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      status <= `RST_WORD;
      alert_out_n <= 1'b1;
      input_bus_enable <= 1'b1;
      power_good_out <= 1'b0;
    end else begin
      status <= next_status;
      alert_out_n <= ~|next_status;
      if (cut_set) input_bus_enable <= 1'b0;
      else if (cut_clr) input_bus_enable <= 1'b1;
      power_good_out <= &(chan_good | ~power_good_map);
    end
  end

  // Read path; unmapped offsets and write-only commands read as zero.
  wire [31:0] rd_mux =
    (addr[7:5] == 3'h0) ? chan_cfg[addr[4:2]] :
    hit(addr, `REG_GLOBAL_CFG) ? global_config :
    hit(addr, `REG_OPERATION) ? {31'h0, op_on} :
    hit(addr, `REG_RESTART_DELAY) ? {16'h0, restart_delay} :
    hit(addr, `REG_RETRY_DELAY) ? {16'h0, retry_delay} :
    hit(addr, `REG_PERSIST) ? {24'h0, persist_limit} :
    hit(addr, `REG_CUT_OV) ? {24'h0, input_cut_on_overvolt} :
    hit(addr, `REG_CUT_UV) ? {24'h0, input_cut_on_undervolt} :
    hit(addr, `REG_PG_MAP) ? {24'h0, power_good_map} :
    hit(addr, `REG_STATUS) ? status :
    hit(addr, `REG_CHAN_STATE) ? {14'h0, power_good_out, input_bus_enable, latched,
                                   converter_enable} : 32'h0000_0000;
  always_ff @(posedge ref_clk) begin
    if (core_rst || !rd) rdata <= 32'h0000_0000;
    else rdata <= rd_mux;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (core_rst);

  a_alert_follows_status: assert property ((status != 32'h0) |-> !alert_out_n)
    else $error("alert released with status pending");
  a_clear_releases_alert: assert property (clear_cmd && status_set == 32'h0 |=>
    alert_out_n && status == 32'h0)
    else $error("clear faults left alert or status");
  a_restart_opens_hold: assert property (restart_pulse[0] |=> restart_hold[0] [*2])
    else $error("restart pulse did not open hold window");
  a_restart_holds_off: assert property (restart_hold[chan_cfg[0][`CFG_CTRL_SEL]] |-> ##1
    !converter_enable[0])
    else $error("channel enabled during restart hold");
  a_fault_disables: assert property (state[0] == CH_ON && fault_trip[0] && vin_ok |=>
    !converter_enable[0] && state[0] == CH_FAULTED)
    else $error("fault did not disable channel");
  a_retry_waits: assert property ($rose(faulted[0]) && chan_cfg[0][`CFG_RETRY]
    && retry_delay > 16'h1 |-> !converter_enable[0] [*3])
    else $error("retry came back too soon");
  a_latch_holds: assert property (latched[0] && !op_on_cmd && !vin_rise && !(|ctrl_rise)
    |=> faulted[0])
    else $error("latched fault left without a clear");
  a_input_cut: assert property (ov_now[0] && input_cut_on_overvolt[0] |=>
    !input_bus_enable)
    else $error("input bus enable not cut on fault");
  a_input_release: assert property (op_on_cmd && !cut_set |=> input_bus_enable)
    else $error("input bus enable not released");
  a_zone_propagate: assert property (faulted[0] && chan_cfg[0][`CFG_PROPAGATE] |=>
    zone_fault_line_n_oe[0])
    else $error("faulted channel did not pull zone line");
  a_zone_shutdown: assert property (zone_trip[3] && vin_ok && state[3] == CH_ON |=>
    !converter_enable[3] ##1 state[3] != CH_ON)
    else $error("zone trip did not shut channel");
  a_input_off_all: assert property (!vin_ok |=> converter_enable == 8'h00)
    else $error("channel enabled with input below off");
  // The reset flop lags the pin by one cycle, so it is held against the pin one cycle back.
  a_wd_reset: assert property (disable iff (srst) wd_rst |-> !$past(wd_lvl_n))
    else $error("watchdog reset without low pin");

  c_restart: cover property (restart_pulse[0] ##[1:1000] converter_enable[0]);
  c_retry: cover property ($fell(faulted[0]) && chan_cfg[0][`CFG_RETRY]);
  c_zone_trip: cover property (state[0] == CH_ZONE_HOLD ##[1:1000] state[0] == CH_OFF);
  c_latch_clear: cover property (latched[0] ##1 !faulted[0]);

endmodule // power_channel_fault_manager

//--- shared/fault_mgr_cfg.svh
`ifndef FAULT_MGR_CFG_SVH
`define FAULT_MGR_CFG_SVH

// Clock rate and the microsecond time base.
`define CLK_MHZ 50
`define TICK_NS 1000
`define TICK_CYCLES ((`TICK_NS * `CLK_MHZ) / 1000)
`define TICK_LAST 6'h31

// Minimum off time of a restart pulse and deglitch time of a fault line, in us.
`define RESTART_MIN_US 4'ha
`define DEGLITCH_US 4'ha

// Least low time of the watchdog reset pin and its count, rounded up.
`define RESET_PULSE_NS 1000
`define RESET_CYCLES (((`RESET_PULSE_NS * `CLK_MHZ) + 999) / 1000)

// Register byte offsets.
`define REG_CHAN_CFG 8'h00
`define REG_GLOBAL_CFG 8'h20
`define REG_OPERATION 8'h24
`define REG_CLEAR_FAULTS 8'h28
`define REG_RESTART_DELAY 8'h2c
`define REG_RETRY_DELAY 8'h30
`define REG_PERSIST 8'h34
`define REG_CUT_OV 8'h38
`define REG_CUT_UV 8'h3c
`define REG_PG_MAP 8'h40
`define REG_STATUS 8'h44
`define REG_CHAN_STATE 8'h48

// Field positions of channel_config.
`define CFG_CTRL_SEL 0
`define CFG_OV_RESP 1
`define CFG_UV_RESP 3
`define CFG_RETRY 5
`define CFG_PROPAGATE 7
`define CFG_RESPONSE 9
`define CFG_TON 16
`define CFG_TOFF 24

// Fault response codes.
`define RESP_CONTINUE 2'h0
`define RESP_IMMEDIATE 2'h1
`define RESP_PERSIST 2'h2

// Bits of global_config and operation.
`define GCFG_VIN_SHARE 0
`define OP_ON 0

// Reset values.
`define RST_WORD 32'h0000_0000
`define RST_OP 1'h1
`define RST_PG_MAP 8'hff
`define RST_CTRL_PREV 2'h3

`endif

//--- shared/fault_mgr_pkg.sv
package fault_mgr_pkg;

  // Sequencing state of one channel.
  typedef enum logic [2:0] {
    CH_OFF,
    CH_DELAY_ON,
    CH_ON,
    CH_DELAY_OFF,
    CH_FAULTED,
    CH_ZONE_HOLD
  } chan_state_e;

endpackage

//--- sim/converter_array_model.sv
`timescale 1ns/1ps

// Converters, peer managers and the pulled-up zone wiring on the far side.
module converter_array_model (
  input wire logic ref_clk,
  input wire logic [7:0] converter_enable,
  input wire logic [3:0] zone_out,
  input wire logic [3:0] zone_oe,
  input wire logic [3:0] peer_pull,
  output logic [7:0] chan_good,
  output logic [3:0] zone_n
);
  logic [7:0] up1;
  logic [7:0] up2;

  // Outputs need two cycles to come up, but collapse at once when disabled.
  always_ff @(posedge ref_clk) begin
    up1 <= converter_enable;
    up2 <= up1 & converter_enable;
  end
  assign chan_good = up2 & converter_enable;

  // Open-drain lines with a pull-up, so any party pulling wins.
  assign zone_n = (~zone_oe | zone_out) & ~peer_pull;
endmodule // converter_array_model

//--- sim/tb.sv
`timescale 1ns/1ps
`include "fault_mgr_cfg.svh"

module tb;
  logic ref_clk, srst, wr, rd, vin_above_on, vin_below_off, watchdog_reset_in_n;
  logic [7:0] addr, ov_fault_cmp, uv_fault_cmp, ov_warn, uv_warn, chan_good, en, p1, w1, w2;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] control_pin;
  logic [3:0] zone_in, zone_out, zone_oe, peer_pull;
  logic input_bus_enable, alert_out_n, power_good_out, share_clk;
  logic [7:0] ra [5];
  logic [31:0] rx [5];
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int k;

  power_channel_fault_manager DUT (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .control_pin(control_pin), .vin_above_on(vin_above_on),
    .vin_below_off(vin_below_off), .share_clk_in(share_clk),
    .watchdog_reset_in_n(watchdog_reset_in_n), .ov_fault_cmp(ov_fault_cmp),
    .uv_fault_cmp(uv_fault_cmp), .ov_warn(ov_warn), .uv_warn(uv_warn), .chan_good(chan_good),
    .zone_fault_line_n_in(zone_in), .zone_fault_line_n_out(zone_out),
    .zone_fault_line_n_oe(zone_oe), .converter_enable(en),
    .input_bus_enable(input_bus_enable), .alert_out_n(alert_out_n),
    .power_good_out(power_good_out));

  converter_array_model far_side (.ref_clk(ref_clk), .converter_enable(en), .zone_out(zone_out),
    .zone_oe(zone_oe), .peer_pull(peer_pull), .chan_good(chan_good), .zone_n(zone_in));

  // Free-running 50 MHz clock.
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  // A hang is cut short well past the longest expected run.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask

  // Bus cycles: one strobe cycle each, read data taken in the following cycle only.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic wait_us(input int n);
    repeat (n * 50) @(posedge ref_clk);
  endtask

  // Immediate overvolt shutdown, latch-off, zone line 0 both ways, 1 us on and 3 us off delays.
  // The off delay is long enough that a one-tick phase error cannot hide it.
  function automatic logic [31:0] cfg_word(input logic sel);
    return {8'h03, 8'h01, 5'h00, 2'h1, 2'h1, 1'b0, 1'b0, 2'h0, 2'h1, sel};
  endfunction

  function automatic logic [7:0] zone_mask(input int ch);
    return (ch < 4) ? 8'h0f : 8'hf0;
  endfunction

  // Main sequence; the random draws pick channels, pin mapping and warning patterns.
  initial begin
    srst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    control_pin = 2'h3;
    vin_above_on = 1'b1;
    vin_below_off = 1'b0;
    watchdog_reset_in_n = 1'b1;
    {ov_fault_cmp, uv_fault_cmp, ov_warn, uv_warn} = 32'h0;
    peer_pull = 4'h0;
    share_clk = 1'b0;
    ra = '{`REG_CHAN_CFG, `REG_OPERATION, `REG_PG_MAP, `REG_STATUS, 8'h4c};
    rx = '{32'h0, 32'h1, 32'hff, 32'h0, 32'h0};
    void'($urandom(69502));
    repeat (5) @(posedge ref_clk);
    chk("reset enables", 32'h0, en);
    chk("reset alert", 32'h1, alert_out_n);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus_rd(ra[i]);
      chk("reset read", rx[i], rv);
    end
    p1 = 8'($urandom);
    p1[0] = 1'b0;
    p1[7] = 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus_wr(`REG_CHAN_CFG + 8'(4 * i), cfg_word(p1[i]));
    end
    bus_wr(`REG_CUT_OV, 32'hff);
    bus_wr(`REG_CLEAR_FAULTS, 32'h0);
    wait_us(3);
    chk("all on", 32'hff, en);
    chk("power good", 32'h1, power_good_out);
    bus_rd(`REG_CHAN_STATE);
    chk("state", 32'h0003_00ff, rv);
    w1 = 8'($urandom) | 8'h01;
    w2 = 8'($urandom) | 8'h80;
    ov_warn <= w1;
    uv_warn <= w2;
    repeat (3) @(posedge ref_clk);
    ov_warn <= 8'h00;
    uv_warn <= 8'h00;
    repeat (3) @(posedge ref_clk);
    chk("warn alert", 32'h0, alert_out_n);
    chk("warn enables", 32'hff, en);
    bus_rd(`REG_STATUS);
    chk("warn status", {w2, w1, 16'h0}, rv);
    bus_wr(`REG_CLEAR_FAULTS, 32'h0);
    bus_rd(`REG_STATUS);
    chk("cleared status", 32'h0, rv);
    chk("alert released", 32'h1, alert_out_n);
    k = $urandom % 8;
    ov_fault_cmp[k] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ov_fault_cmp <= 8'h00;
    repeat (2) @(posedge ref_clk);
    chk("faulted enable", 32'h0, en[k]);
    chk("input cut", 32'h0, input_bus_enable);
    chk("zone pull", 32'h1, zone_oe[2 * (k / 4)]);
    chk("good drop", 32'h0, power_good_out);
    wait_us(5);
    chk("deglitch", {24'h0, 8'hff & ~(8'h01 << k)}, en);
    wait_us(7);
    chk("zone trip", {24'h0, ~zone_mask(k)}, en);
    bus_rd(`REG_STATUS);
    chk("fault status", 32'h1 << k, rv);
    bus_wr(`REG_PG_MAP, {24'h0, ~zone_mask(k)});
    repeat (3) @(posedge ref_clk);
    chk("mapped good", 32'h1, power_good_out);
    bus_wr(`REG_OPERATION, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk("input restored", 32'h1, input_bus_enable);
    wait_us(3);
    chk("latch cleared", 32'hff, en);
    bus_wr(`REG_CLEAR_FAULTS, 32'h0);
    bus_wr(`REG_RESTART_DELAY, 32'h8);
    control_pin[1] <= 1'b0;
    wait_us(12);
    control_pin[1] <= 1'b1;
    chk("pin select", {24'h0, ~p1}, en);
    wait_us(4);
    chk("restart hold", {24'h0, ~p1}, en);
    wait_us(8);
    chk("restart done", 32'hff, en);
    control_pin[0] <= 1'b0;
    repeat (100) @(posedge ref_clk);
    chk("off delay", 32'hff, en);
    wait_us(2);
    chk("off done", {24'h0, p1}, en);
    control_pin[0] <= 1'b1;
    wait_us(3);
    peer_pull <= 4'h8;
    wait_us(12);
    chk("unmasked line", 32'hff, en);
    peer_pull <= 4'h4;
    wait_us(12);
    chk("external trip", 32'h0f, en);
    peer_pull <= 4'h0;
    wait_us(3);
    chk("zone restart", 32'hff, en);
    // Retry mode: the channel stays off for at least three ticks of the delay, then returns.
    bus_wr(`REG_RETRY_DELAY, 32'h4);
    bus_wr(`REG_CHAN_CFG + 8'(4 * k), cfg_word(p1[k]) | (32'h1 << `CFG_RETRY));
    ov_fault_cmp[k] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ov_fault_cmp <= 8'h00;
    wait_us(2);
    chk("retry wait", 32'h0, en[k]);
    wait_us(4);
    chk("retry done", 32'hff, en);
    // With sharing on, input loss waits for a rising share clock.
    bus_wr(`REG_GLOBAL_CFG, 32'h1);
    vin_below_off <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("share wait", 32'hff, en);
    share_clk <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("input loss", 32'h0, en);
    vin_below_off <= 1'b0;
    share_clk <= 1'b0;
    bus_wr(`REG_GLOBAL_CFG, 32'h0);
    wait_us(3);
    chk("input back", 32'hff, en);
    watchdog_reset_in_n <= 1'b0;
    repeat (60) @(posedge ref_clk);
    chk("watchdog", 32'h0, en);
    watchdog_reset_in_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    bus_rd(`REG_RESTART_DELAY);
    chk("watchdog regs", 32'h0, rv);
    summarize();
  end
endmodule // tb
